/* File: pwr_ctl_pkg.sv */
package pwr_ctl_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] WDOG_REG_OFS = 8'h14;
	localparam logic [7:0] SUPPLY_REG_OFS = 8'h15;
	localparam logic [7:0] STATUS_REG_OFS = 8'h20;
	localparam logic [7:0] OPTION_REG_OFS = 8'h21;
	localparam int WDOG_FLAG_BIT = 3;
	localparam logic [3:0] SUPPLY_RESET_VAL = 4'h0;
	localparam logic [3:0] SUPPLY_DISABLE_KEY = 4'hA;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [15:0] OP_HALT = 16'hD800;
	localparam logic [15:0] OP_STOP = 16'hDC00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int WARMUP_CYCLES = 8192;
	localparam int WDOG_TIMEOUT_MS = 16;
	localparam int RC_FREQ_KHZ = 4000;
	localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * RC_FREQ_KHZ / 1000;
	localparam logic [15:0] WDOG_LOAD = 16'hFFFF;
	// ****************************************
	// Types
	// ****************************************
	typedef enum {ST_WARMUP, ST_RUN, ST_HALT, ST_STOP} pwr_state_t;
	typedef struct packed {
		logic powerOn;
		logic lowSupply;
		logic watchdog;
	} rst_cause_t;
endpackage

/* File: power_mode_reset_watchdog.sv */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
// Behaviour
// R1: Halt opcode stops CPU fetch and execution.
// R2: Stop opcode gates all clocks and stops the oscillator.
// R3: Timer keeps its clock in halt mode.
// R4: Any interrupt wakes the device from halt.
// R5: Only a port interrupt wakes the device from stop.
// R6: Warm-up runs after power-on, low-supply reset and stop wake-up.
// R7: Warm-up lasts 8192 oscillator clocks.
// R8: Enabled supply monitor below threshold asserts system reset.
// R9: Monitor disabled only by key 1010; field powers up 0000.
// R10: Watchdog is a 16-bit down counter on the RC oscillator.
// R11: Watchdog overflow forces a full device reset; here no warm-up, monitor field kept and powerOnReset not pulsed.
// R12: Writing one to bit 3 restarts watchdog; software must do so.
// R13: Watchdog timeout is about sixteen milliseconds after restart.
// R14: Flag reads 1 after power-on/low-supply, 0 after watchdog reset.
// R15: Stop wake-up clears the watchdog counter.
// R16: Three reset sources, each forcing program counter to zero.
// R17: Monitor field cleared by power-on/low-supply, kept on watchdog.
// R18: Every reset returns port pins to input.
// R19: Only power-on clears timer, load and pulldown enable.
// R20: Carrier low reload is kept across low-supply and watchdog resets.
// R21: Oscillator option selects internal RC or external resonator.
// R22: Option selects ports two/three, or also port four, as wake sources.
// R23: Rising edge on selected pin interrupts; rearm after all low.
// R24: Reset and idle CPU held until warm-up completes.
module power_mode_reset_watchdog (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic rcTick,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// CPU side
	input wire logic [15:0] opcode,
	input wire logic opValid,
	input wire logic timerIrq,
	output logic cpuRun,
	output logic cpuClkEn,
	output logic timerClkEn,
	output logic oscEn,
	output logic pcClear,
	output logic coreReset,
	output logic powerOnReset,
	output logic portDirReset,
	output logic portIrq,
	// Supply monitor and options
	input wire logic supplyLow,
	input wire logic oscSelectOpt,
	input wire logic portFourOpt,
	output logic extOscSel,
	// Ports
	input wire logic [3:0] portTwo,
	input wire logic [3:0] portThree,
	input wire logic [2:0] portFour
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rstSync1_reg, rstSync2_reg;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	wire logic sysRst_b = rstSync2_reg;

	// ****************************************
	// State and registers
	// ****************************************
	pwr_ctl_pkg::pwr_state_t state_reg;
	pwr_ctl_pkg::rst_cause_t cause_reg;
	logic [12:0] warm_reg;
	logic [15:0] wdog_reg;
	logic wdogFlag_reg;
	logic [3:0] supply_reg;
	logic intReset_reg;
	logic armed_reg;
	logic porPending_reg;
	logic lowPending_reg;
	logic wdogPending_reg;

	function automatic logic isOp(input logic [15:0] op, input logic [15:0] ref_op);
		return op == ref_op;
	endfunction

	wire logic [10:0] selPins = {portFourOpt ? portFour : 3'h0, portThree, portTwo}; // see R22
	logic [10:0] pinsPrev_reg;
	wire logic pinRise = |(selPins & ~pinsPrev_reg);
	wire logic portEvent = pinRise && armed_reg; // see R23
	wire logic monEnabled = supply_reg != pwr_ctl_pkg::SUPPLY_DISABLE_KEY; // see R9
	wire logic lowTrip = supplyLow && monEnabled; // see R8
	wire logic wdogTrip = (wdog_reg == 16'h0000) && rcTick && state_reg != pwr_ctl_pkg::ST_STOP;
	wire logic wdogRestartWr = write && !waitrequest && address == pwr_ctl_pkg::WDOG_REG_OFS
		&& writedata[pwr_ctl_pkg::WDOG_FLAG_BIT];

	// ****************************************
	// Port edge detect
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			pinsPrev_reg <= 11'h000;
			armed_reg <= 1'b0;
		end else if (clkEn) begin
			pinsPrev_reg <= selPins;
			if (portEvent) begin
				armed_reg <= 1'b0; // see R23
			end else if (selPins == 11'h000) begin
				armed_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// Power state machine
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			state_reg <= pwr_ctl_pkg::ST_WARMUP;
			warm_reg <= 13'h0000;
		end else if (clkEn) begin
			if (lowTrip || wdogTrip) begin
				state_reg <= lowTrip ? pwr_ctl_pkg::ST_WARMUP : pwr_ctl_pkg::ST_RUN; // see R6
				warm_reg <= 13'h0000;
			end else begin
				case (state_reg)
					pwr_ctl_pkg::ST_WARMUP: begin
						warm_reg <= warm_reg + 13'h0001; // see R7
						if (warm_reg == 13'(pwr_ctl_pkg::WARMUP_CYCLES - 1)) begin
							state_reg <= pwr_ctl_pkg::ST_RUN; // see R24
						end
					end
					pwr_ctl_pkg::ST_RUN: begin
						if (opValid && isOp(opcode, pwr_ctl_pkg::OP_HALT)) begin
							state_reg <= pwr_ctl_pkg::ST_HALT; // see R1
						end else if (opValid && isOp(opcode, pwr_ctl_pkg::OP_STOP)) begin
							state_reg <= pwr_ctl_pkg::ST_STOP; // see R2
						end
					end
					pwr_ctl_pkg::ST_HALT: begin
						if (timerIrq || portEvent) begin
							state_reg <= pwr_ctl_pkg::ST_RUN; // see R4
						end
					end
					pwr_ctl_pkg::ST_STOP: begin
						if (portEvent) begin
							state_reg <= pwr_ctl_pkg::ST_WARMUP; // see R5
							warm_reg <= 13'h0000; // see R6
						end
					end
					default: state_reg <= pwr_ctl_pkg::ST_WARMUP;
				endcase
			end
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			wdog_reg <= pwr_ctl_pkg::WDOG_LOAD;
		end else if (clkEn) begin
			if (wdogRestartWr || wdogTrip || lowTrip) begin
				wdog_reg <= pwr_ctl_pkg::WDOG_LOAD; // see R12
			end else if (state_reg == pwr_ctl_pkg::ST_STOP && portEvent) begin
				wdog_reg <= pwr_ctl_pkg::WDOG_LOAD; // see R15
			end else if (rcTick && state_reg != pwr_ctl_pkg::ST_STOP) begin
				wdog_reg <= wdog_reg - 16'h0001; // see R10 R13
			end
		end
	end

	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			wdogFlag_reg <= 1'b1;
		end else if (clkEn) begin
			if (wdogTrip) begin
				wdogFlag_reg <= 1'b0; // see R14
			end else if (lowTrip) begin
				wdogFlag_reg <= 1'b1; // see R14
			end
		end
	end

	// ****************************************
	// Supply monitor field
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			supply_reg <= pwr_ctl_pkg::SUPPLY_RESET_VAL; // see R9
		end else if (clkEn) begin
			if (lowTrip) begin
				supply_reg <= pwr_ctl_pkg::SUPPLY_RESET_VAL; // see R17
			end else if (write && !waitrequest && address == pwr_ctl_pkg::SUPPLY_REG_OFS) begin
				supply_reg <= writedata[3:0];
			end
		end
	end

	// ****************************************
	// Reset cause and pulses
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			cause_reg <= '{powerOn: 1'b1, lowSupply: 1'b0, watchdog: 1'b0};
			porPending_reg <= 1'b1;
			lowPending_reg <= 1'b0;
			wdogPending_reg <= 1'b0;
		end else if (clkEn) begin
			if (lowTrip || wdogTrip) begin
				cause_reg <= '{powerOn: 1'b0, lowSupply: lowTrip, watchdog: !lowTrip}; // see R16
				lowPending_reg <= lowTrip;
				wdogPending_reg <= !lowTrip; // see R11
			end else if (state_reg == pwr_ctl_pkg::ST_RUN) begin
				porPending_reg <= 1'b0;
				lowPending_reg <= 1'b0;
				wdogPending_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			intReset_reg <= 1'b1;
		end else if (clkEn) begin
			intReset_reg <= lowTrip || wdogTrip || porPending_reg || lowPending_reg
				|| wdogPending_reg; // see R24
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			cpuRun <= 1'b0;
			cpuClkEn <= 1'b0;
			timerClkEn <= 1'b0;
			oscEn <= 1'b1;
			pcClear <= 1'b1;
			coreReset <= 1'b1;
			powerOnReset <= 1'b1;
			portDirReset <= 1'b1;
			portIrq <= 1'b0;
			extOscSel <= 1'b0;
		end else if (clkEn) begin
			cpuRun <= state_reg == pwr_ctl_pkg::ST_RUN && !intReset_reg; // see R24
			cpuClkEn <= state_reg == pwr_ctl_pkg::ST_RUN; // see R1
			timerClkEn <= state_reg == pwr_ctl_pkg::ST_RUN
				|| state_reg == pwr_ctl_pkg::ST_HALT; // see R3
			oscEn <= state_reg != pwr_ctl_pkg::ST_STOP; // see R2
			pcClear <= intReset_reg; // see R16
			coreReset <= intReset_reg;
			powerOnReset <= porPending_reg; // see R19 R20
			portDirReset <= intReset_reg; // see R18
			portIrq <= portEvent; // see R23
			extOscSel <= oscSelectOpt; // see R21
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	always_ff @(posedge mclk or negedge sysRst_b) begin
		if (!sysRst_b) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else if (clkEn) begin
			waitrequest <= !((read || write) && waitrequest);
			if (read && waitrequest) begin
				case (address)
					pwr_ctl_pkg::WDOG_REG_OFS: readdata <= {28'h0, wdogFlag_reg, 3'h0};
					pwr_ctl_pkg::SUPPLY_REG_OFS: readdata <= {28'h0, supply_reg};
					pwr_ctl_pkg::STATUS_REG_OFS: readdata <= {25'h0, cause_reg,
						2'(state_reg), monEnabled, armed_reg};
					pwr_ctl_pkg::OPTION_REG_OFS: readdata <= {30'h0, portFourOpt, oscSelectOpt};
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // power_mode_reset_watchdog

/* File: power_mode_reset_watchdog_chk.sv */
`timescale 1ns/100ps
module power_mode_reset_watchdog_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Bus
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Core side
	input wire logic [15:0] opcode,
	input wire logic opValid,
	input wire logic cpuRun,
	input wire logic cpuClkEn,
	input wire logic timerClkEn,
	input wire logic oscEn,
	input wire logic pcClear,
	input wire logic coreReset,
	input wire logic powerOnReset,
	input wire logic portDirReset,
	input wire logic portIrq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	int warmCnt;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			warmCnt <= 0;
		else
			warmCnt <= powerOnReset ? warmCnt + 1 : 0;
	end
	a_halt_gates_cpu: assert property (
		opValid && opcode == pwr_ctl_pkg::OP_HALT && cpuRun |-> ##[1:3] !cpuClkEn && timerClkEn)
		else $error("halt left cpu clock on");
	a_stop_osc_off: assert property (
		opValid && opcode == pwr_ctl_pkg::OP_STOP && cpuRun |-> ##[1:3] !oscEn)
		else $error("stop left oscillator on");
	a_ack_one_cycle: assert property (!waitrequest && clkEn |=> waitrequest)
		else $error("waitrequest low too long");
	a_bus_answer: assert property ((read || write) && waitrequest && clkEn |=> !waitrequest)
		else $error("bus request not answered");
	a_read_upper: assert property (!waitrequest |-> readdata[31:7] == 25'h0000000)
		else $error("upper read bits set");
	a_warmup_length: assert property (
		$fell(powerOnReset) |-> warmCnt >= pwr_ctl_pkg::WARMUP_CYCLES)
		else $error("warm-up too short");
	a_port_pulse: assert property (portIrq |=> !portIrq)
		else $error("port event longer than a cycle");
	a_reset_outputs: assert property (coreReset |-> pcClear && portDirReset && !cpuRun)
		else $error("reset outputs disagree");
endmodule // power_mode_reset_watchdog_chk
bind power_mode_reset_watchdog power_mode_reset_watchdog_chk chk_u (.mclk(mclk), .rst_b(rst_b),
	.clkEn(clkEn),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .opcode(opcode),
	.opValid(opValid), .cpuRun(cpuRun), .cpuClkEn(cpuClkEn), .timerClkEn(timerClkEn), .oscEn(oscEn),
	.pcClear(pcClear), .coreReset(coreReset), .powerOnReset(powerOnReset),
	.portDirReset(portDirReset), .portIrq(portIrq));

/* File: cpu_port_model.sv */
`timescale 1ns/100ps
module cpu_port_model (
	// Clock and run state
	input wire logic mclk,
	input wire logic cpuRun,
	// Driven into the block
	output logic [15:0] opcode,
	output logic opValid,
	output logic timerIrq,
	output logic [3:0] portTwo,
	output logic [3:0] portThree,
	output logic [2:0] portFour
);
	initial begin
		opcode = 16'hFFFF;
		opValid = 1'b0;
		timerIrq = 1'b0;
		{portTwo, portThree, portFour} = 11'h000;
	end
	// Core issues only while allowed to run
	task exec(input logic [15:0] op);
		@(negedge mclk);
		while (cpuRun !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		opcode <= op;
		opValid <= 1'b1;
		@(posedge mclk);
		opValid <= 1'b0;
		opcode <= ~op;
	endtask
	task irq(input logic lvl);
		@(posedge mclk);
		timerIrq <= lvl;
	endtask
	task pins(input logic [10:0] lvl);
		@(posedge mclk);
		{portTwo, portThree, portFour} <= lvl;
	endtask
endmodule // cpu_port_model

/* File: testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic rcTick = 1'b0;
	logic supplyLow = 1'b0;
	logic clkEn = 1'b1;
	logic oscSelectOpt = 1'b1;
	logic portFourOpt = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata, q;
	logic waitrequest, cpuRun, cpuClkEn, timerClkEn, oscEn, pcClear, coreReset, powerOnReset;
	logic portDirReset, portIrq, extOscSel, opValid, timerIrq;
	logic [15:0] opcode;
	logic [3:0] portTwo, portThree;
	logic [2:0] portFour;
	int errors = 0;
	int nCompared = 0;
	int cyc = 0;
	int n;
	always #2 mclk = ~mclk;
	power_mode_reset_watchdog dut_u (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .rcTick(rcTick),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .opcode(opcode), .opValid(opValid),
		.timerIrq(timerIrq), .cpuRun(cpuRun), .cpuClkEn(cpuClkEn), .timerClkEn(timerClkEn),
		.oscEn(oscEn), .pcClear(pcClear), .coreReset(coreReset), .powerOnReset(powerOnReset),
		.portDirReset(portDirReset), .portIrq(portIrq), .supplyLow(supplyLow),
		.oscSelectOpt(oscSelectOpt), .portFourOpt(portFourOpt), .extOscSel(extOscSel),
		.portTwo(portTwo),
		.portThree(portThree), .portFour(portFour));
	cpu_port_model model_u (.mclk(mclk), .cpuRun(cpuRun), .opcode(opcode), .opValid(opValid),
		.timerIrq(timerIrq), .portTwo(portTwo), .portThree(portThree), .portFour(portFour));
	// ****************************************
	// Shared tasks
	// ****************************************
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0) @(posedge mclk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task waitRun();
		while (cpuRun !== 1'b0) @(negedge mclk);
		n = 0;
		while (cpuRun !== 1'b1) begin
			@(negedge mclk);
			n++;
		end
	endtask
	task checkWarm();
		waitRun();
		`CHK(n >= pwr_ctl_pkg::WARMUP_CYCLES && n <= 8210, 1'b1)
	endtask
	task end_of_test();
		$display("errors %0d compared %0d", errors, nCompared);
		if (errors == 0 && nCompared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			errors++;
			end_of_test();
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task tReset();
		@(negedge mclk);
		`CHK({coreReset, portDirReset, pcClear, cpuRun}, 4'hE)
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		checkWarm();
		`CHK(extOscSel, 1'b1)
	endtask
	task tRegs();
		bus(1'b0, pwr_ctl_pkg::SUPPLY_REG_OFS, 32'h0);
		`CHK(q[3:0], pwr_ctl_pkg::SUPPLY_RESET_VAL)
		bus(1'b0, pwr_ctl_pkg::WDOG_REG_OFS, 32'h0);
		`CHK(q[pwr_ctl_pkg::WDOG_FLAG_BIT], 1'b1)
		bus(1'b0, 8'h30, 32'h0);
		`CHK(q, 32'h00000000)
		@(posedge mclk);
		clkEn <= 1'b0;
		oscSelectOpt <= 1'b0;
		repeat (3) @(posedge mclk);
		`CHK(extOscSel, 1'b1)
		clkEn <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(extOscSel, 1'b0)
		bus(1'b0, pwr_ctl_pkg::OPTION_REG_OFS, 32'h0);
		`CHK(q[1:0], 2'h0)
	endtask
	task tSupply();
		bus(1'b1, pwr_ctl_pkg::SUPPLY_REG_OFS, {28'h0, pwr_ctl_pkg::SUPPLY_DISABLE_KEY});
		supplyLow <= 1'b1;
		repeat (10) @(negedge mclk);
		`CHK(coreReset, 1'b0)
		@(posedge mclk);
		supplyLow <= 1'b0;
		bus(1'b1, pwr_ctl_pkg::SUPPLY_REG_OFS, 32'h5);
		supplyLow <= 1'b1;
		repeat (3) @(posedge mclk);
		supplyLow <= 1'b0;
		checkWarm();
		bus(1'b0, pwr_ctl_pkg::SUPPLY_REG_OFS, 32'h0);
		`CHK(q[3:0], 4'h0)
	endtask
	task tHalt();
		model_u.exec(pwr_ctl_pkg::OP_HALT);
		repeat (4) @(negedge mclk);
		`CHK({cpuRun, cpuClkEn, timerClkEn}, 3'h1)
		model_u.irq(1'b1);
		repeat (4) @(negedge mclk);
		`CHK(cpuRun, 1'b1)
		model_u.irq(1'b0);
		portFourOpt <= 1'b1;
		model_u.exec(pwr_ctl_pkg::OP_HALT);
		repeat (4) @(negedge mclk);
		`CHK(cpuClkEn, 1'b0)
		model_u.pins(11'h004);
		repeat (4) @(negedge mclk);
		`CHK(cpuRun, 1'b1)
		bus(1'b0, pwr_ctl_pkg::STATUS_REG_OFS, 32'h0);
		`CHK(q[0], 1'b0)
		model_u.pins(11'h000);
		bus(1'b0, pwr_ctl_pkg::STATUS_REG_OFS, 32'h0);
		`CHK(q[0], 1'b1)
		portFourOpt <= 1'b0;
	endtask
	task tStop();
		model_u.exec(pwr_ctl_pkg::OP_STOP);
		model_u.irq(1'b1);
		model_u.pins(11'h007);
		repeat (8) @(negedge mclk);
		`CHK(oscEn, 1'b0)
		model_u.irq(1'b0);
		model_u.pins(11'h000);
		model_u.pins(11'h080);
		checkWarm();
		model_u.pins(11'h000);
	endtask
	task tWdog();
		bus(1'b1, pwr_ctl_pkg::SUPPLY_REG_OFS, 32'h3);
		bus(1'b1, pwr_ctl_pkg::WDOG_REG_OFS, 32'h8);
		rcTick <= 1'b1;
		n = 0;
		while (coreReset !== 1'b1) begin
			@(negedge mclk);
			n++;
		end
		`CHK(n >= 65530 && n <= 65550, 1'b1)
		@(posedge mclk);
		rcTick <= 1'b0;
		waitRun();
		`CHK(n < 64, 1'b1)
		bus(1'b0, pwr_ctl_pkg::WDOG_REG_OFS, 32'h0);
		`CHK(q[pwr_ctl_pkg::WDOG_FLAG_BIT], 1'b0)
		bus(1'b0, pwr_ctl_pkg::SUPPLY_REG_OFS, 32'h0);
		`CHK(q[3:0], 4'h3)
	endtask
	initial begin
		tReset();
		tRegs();
		tSupply();
		tHalt();
		tStop();
		tWdog();
		end_of_test();
	end
endmodule // testbench
